/* core/pce_core.v */
/*
 control logic of a 1024 byte serial card eeprom with one protect flag
 per byte and an optional security code with error counter.
 assumes the card pins (strobe, card clock, data line input) are
 asynchronous to clock and far slower; the data line is open drain
 with an outside pull-up.
*/
// Operation
// - array of 1024 bytes, each with its own protect flag
// - plain variant reads every byte at any time, no verification
// - write programs only bits not already written
// - erase acts on whole bytes; bits may be written singly
// - set protect flag blocks writes and erases; flag never clears
// - secure variant reads all but code bytes at any time
// - secure variant blocks writes and erases until code verified
// - error counter bits writable without code, erase needs code; eight misses block verification
// - power-on reset state held until strobe reset completes
// - reset starts at strobe rise, ends at next card clock rise
// - any reset aborts the command in progress
// - no modification after power-on until a read was done
// - answer-to-reset zeroes address, streams bits from address 0
// - strobe high carries commands in, strobe low carries data out
// - three command bytes; code 100011 writes byte with flag
// - code 110011 writes byte with input data, flag untouched
// - code 000011 sets flag, third byte is comparison data
// - code 001100 reads nine bits: data then protect flag
// - code 011100 reads eight data bits; third byte ignored
// - erase-then-write takes 203 pulses, single operation 103
// - completion pulls data line low until next strobe rise
// - address advances after eighth or ninth read pulse
// - flag set only when comparison data equals stored byte
`timescale 1ns/1ns
`include "pce_regs.vh"
module pce_core
#(
	parameter       SECURE_VARIANT = 1,
	parameter [7:0] CODE_LOW       = 8'hFF,
	parameter [7:0] CODE_HIGH      = 8'hFF
)
(
	input  wire clock,
	input  wire arst_n,
	input  wire strobe_pin,
	input  wire card_clock_pin,
	input  wire io_in,
	output wire io_out,
	output reg  io_oe,
	output reg  por_active,
	output reg  read_seen,
	output reg  code_verified,
	output reg  busy
);
	localparam [1:0] ST_IDLE = 2'd0;
	localparam [1:0] ST_READ = 2'd1;
	localparam [1:0] ST_BUSY = 2'd2;
	localparam [1:0] ST_DONE = 2'd3;

	// nonvolatile contents; flag 1 means the byte is still open
	reg [7:0] mem_data [0:`PCE_DEPTH-1];
	reg       mem_open [0:`PCE_DEPTH-1];

	wire [2:0] pins_sync;
	reg  [1:0] pins_prev;
	reg  [1:0] state;
	reg        reset_pending;
	reg  [4:0] shift_count;
	reg [23:0] cmd;
	reg  [9:0] addr;
	reg  [3:0] bit_index;
	reg        read_nine;
	reg  [7:0] pulse_count;
	reg  [7:0] pulse_target;
	reg  [7:0] wr_value;
	reg        wr_flag;
	reg        code_low_ok;
	integer    i;

	// delivered state: all erased, open flags, transport code
	initial
	begin
		for (i = 0; i < `PCE_DEPTH; i = i + 1)
		begin
			mem_data[i] = `PCE_ERASED_BYTE;
			mem_open[i] = 1'b1;
		end
		mem_data[`PCE_ADDR_ERRCNT] = `PCE_ERRCNT_INIT;
		mem_data[`PCE_ADDR_CODE1] = CODE_LOW;
		mem_data[`PCE_ADDR_CODE2] = CODE_HIGH;
	end

	pce_sync
	#(
		.WIDTH (3)
	)
	u_sync
	(
		.clock  (clock),
		.arst_n (arst_n),
		.pin    ({io_in, card_clock_pin, strobe_pin}),
		.level  (pins_sync)
	);

	wire strobe     = pins_sync[0];
	wire card_clk   = pins_sync[1];
	wire io_level   = pins_sync[2];
	wire strobe_up  = strobe & ~pins_prev[0];
	wire strobe_dn  = ~strobe & pins_prev[0];
	wire clk_up     = card_clk & ~pins_prev[1];

	// decoded command frame
	wire [5:0] ctl    = cmd[`PCE_CTL_LSB +: 6];
	wire [9:0] c_addr = {cmd[`PCE_A9_POS], cmd[`PCE_A8_POS],
		cmd[`PCE_ALO_LSB +: 8]};
	wire [7:0] c_data = cmd[`PCE_DATA_LSB +: 8];
	wire [7:0] old    = mem_data[c_addr];
	wire       sec    = (SECURE_VARIANT != 0);

	// bits to erase (0 to 1) force a full byte erase first
	wire need_erase = |(~old & c_data);
	wire need_write = need_erase ? (c_data != `PCE_ERASED_BYTE)
		: |(old & ~c_data);
	wire [7:0] op_len = (need_erase && need_write) ?
		`PCE_PULSES_ERASE_WRITE : `PCE_PULSES_SINGLE;

	// gating of every modification
	wire mod_ok  = ~por_active & read_seen;
	wire code_ok = ~sec | code_verified;
	wire data_ok = mod_ok & code_ok & mem_open[c_addr];
	// only writing counter bits is free; erasing needs the code
	wire errcnt_ok = mod_ok & sec & (c_addr == `PCE_ADDR_ERRCNT) &
		(~need_erase | code_verified) & mem_open[c_addr];
	// an exhausted counter refuses every verification
	wire tries_left = (mem_data[`PCE_ADDR_ERRCNT] != 8'h00);

	// current read bit; in the secure variant code bytes read as zero
	wire code_byte = sec & ((addr == `PCE_ADDR_CODE1) |
		(addr == `PCE_ADDR_CODE2));
	wire rd_bit = code_byte ? 1'b0 :
		(bit_index[3] ? mem_open[addr] : mem_data[addr][bit_index[2:0]]);
	wire [3:0] last_bit = read_nine ? `PCE_READ9_LAST : `PCE_READ8_LAST;

	// open drain: the block never drives high
	assign io_out = 1'b0;

	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			pins_prev <= 2'b00;
		else
			pins_prev <= pins_sync[1:0];
	end

	// control state machine
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state         <= ST_IDLE;
			por_active    <= 1'b1;
			reset_pending <= 1'b0;
			read_seen     <= 1'b0;
			code_verified <= 1'b0;
			code_low_ok   <= 1'b0;
			shift_count   <= 5'd0;
			cmd           <= 24'h000000;
			addr          <= 10'h000;
			bit_index     <= 4'h0;
			read_nine     <= 1'b0;
			pulse_count   <= 8'h00;
			pulse_target  <= 8'h00;
			wr_value      <= 8'h00;
			wr_flag       <= 1'b0;
		end
		else if (strobe_up)
		begin
			// every strobe rise starts a reset and drops the command
			state         <= ST_IDLE;
			reset_pending <= 1'b1;
			shift_count   <= 5'd0;
		end
		else if (strobe)
		begin
			if (clk_up)
			begin
				reset_pending <= 1'b0;
				if (reset_pending)
					por_active <= 1'b0;
				cmd <= {io_level, cmd[23:1]};
				if (shift_count != 5'd31)
					shift_count <= shift_count + 5'd1;
			end
		end
		else if (strobe_dn)
		begin
			if (shift_count == 5'd1)
			begin
				// answer-to-reset: stream 8 bits per byte from 0
				state     <= ST_READ;
				addr      <= 10'h000;
				bit_index <= 4'h0;
				read_nine <= 1'b0;
				read_seen <= 1'b1;
			end
			else if (shift_count == `PCE_CMD_BITS)
			begin
				addr         <= c_addr;
				bit_index    <= 4'h0;
				pulse_count  <= 8'h00;
				pulse_target <= op_len;
				wr_value     <= c_data;
				case (ctl)
				`PCE_CMD_READ9, `PCE_CMD_READ8:
				begin
					state     <= ST_READ;
					read_nine <= (ctl == `PCE_CMD_READ9);
					read_seen <= 1'b1;
				end
				`PCE_CMD_WR_PROT:
				begin
					state   <= data_ok ? ST_BUSY : ST_IDLE;
					wr_flag <= 1'b1;
				end
				`PCE_CMD_WR_DATA:
				begin
					state   <= data_ok ? ST_BUSY : ST_IDLE;
					wr_flag <= 1'b0;
				end
				`PCE_CMD_SET_PROT:
				begin
					// comparison data must match the stored byte
					state <= (data_ok && c_data == old) ?
						ST_DONE : ST_IDLE;
				end
				`PCE_CMD_WR_ERRCNT:
				begin
					state   <= errcnt_ok ? ST_BUSY : ST_IDLE;
					wr_flag <= 1'b0;
				end
				`PCE_CMD_VERIFY:
				begin
					state <= ST_IDLE;
					if (sec && mod_ok && tries_left)
					begin
						if (c_addr == `PCE_ADDR_CODE1)
							code_low_ok <= (c_data == old);
						else if (c_addr == `PCE_ADDR_CODE2 &&
							code_low_ok && c_data == old)
						begin
							code_verified <= 1'b1;
							state         <= ST_DONE;
						end
					end
				end
				default:
					state <= ST_IDLE;
				endcase
			end
			else
				state <= ST_IDLE;
		end
		else if (clk_up)
		begin
			case (state)
			ST_READ:
			begin
				if (bit_index == last_bit)
				begin
					bit_index <= 4'h0;
					addr      <= addr + 10'h001;
				end
				else
					bit_index <= bit_index + 4'h1;
			end
			ST_BUSY:
			begin
				// timed by the host, counted in card clock pulses
				if (pulse_count == pulse_target - 8'h01)
					state <= ST_DONE;
				else
					pulse_count <= pulse_count + 8'h01;
			end
			default:
				state <= state;
			endcase
		end
	end

	// array update at the end of a timed write or a flag set
	always @(posedge clock)
	begin
		if (!strobe && !strobe_dn && clk_up && state == ST_BUSY &&
			pulse_count == pulse_target - 8'h01)
		begin
			mem_data[addr] <= wr_value;
			if (wr_flag)
				mem_open[addr] <= 1'b0;
		end
		if (strobe_dn && shift_count == `PCE_CMD_BITS &&
			ctl == `PCE_CMD_SET_PROT && data_ok && c_data == old)
			mem_open[c_addr] <= 1'b0;
	end

	// data line drive: low bits while reading, low after completion
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			io_oe <= 1'b0;
			busy  <= 1'b0;
		end
		else
		begin
			busy  <= (state == ST_BUSY);
			io_oe <= ~strobe & ((state == ST_READ & ~rd_bit) |
				(state == ST_DONE));
		end
	end
endmodule

/* core/pce_regs.vh */
/*
 constants of the protected card eeprom: command codes, special
 addresses, operation lengths in card clock pulses and reset values.
 assumes inclusion by bare name from the core files.
*/
`ifndef PCE_REGS_VH
`define PCE_REGS_VH

// memory shape
`define PCE_ADDR_W        10
`define PCE_DEPTH         1024

// control codes, written {s5,s4,s3,s2,s1,s0}
`define PCE_CMD_WR_PROT   6'h31
`define PCE_CMD_WR_DATA   6'h33
`define PCE_CMD_SET_PROT  6'h30
`define PCE_CMD_READ9     6'h0C
`define PCE_CMD_READ8     6'h0E
`define PCE_CMD_WR_ERRCNT 6'h32
`define PCE_CMD_VERIFY    6'h0D

// command frame field positions
`define PCE_CMD_BITS      5'd24
`define PCE_CTL_LSB       0
`define PCE_A8_POS        6
`define PCE_A9_POS        7
`define PCE_ALO_LSB       8
`define PCE_DATA_LSB      16

// special locations
`define PCE_ADDR_ERRCNT   10'h3FD
`define PCE_ADDR_CODE1    10'h3FE
`define PCE_ADDR_CODE2    10'h3FF

// operation lengths in card clock pulses
`define PCE_PULSES_ERASE_WRITE 8'd203
`define PCE_PULSES_SINGLE      8'd103

// last read bit index per location
`define PCE_READ8_LAST    4'd7
`define PCE_READ9_LAST    4'd8

// delivered contents
`define PCE_ERASED_BYTE   8'hFF
`define PCE_ERRCNT_INIT   8'hFF

`endif

/* core/pce_sync.v */
/*
 two flip-flop synchroniser for a group of pin inputs.
 assumes the pins change slowly against clock; stage one is read
 only by stage two.
*/
`timescale 1ns/1ns
module pce_sync
#(
	parameter WIDTH = 3
)
(
	input  wire             clock,
	input  wire             arst_n,
	input  wire [WIDTH-1:0] pin,
	output reg  [WIDTH-1:0] level
);
	reg [WIDTH-1:0] stage;

	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			stage <= {WIDTH{1'b0}};
			level <= {WIDTH{1'b0}};
		end
		else
		begin
			stage <= pin;
			level <= stage;
		end
	end
endmodule

/* verification/pce_props_properties.sv */
/*
 pin assertions for pce_core.
 assumes pin levels held 4 clocks or more.
*/
`timescale 1ns/1ns
module pce_props
(
	input wire clock,
	input wire arst_n,
	input wire strobe_pin,
	input wire card_clock_pin,
	input wire io_in,
	input wire io_out,
	input wire io_oe,
	input wire por_active,
	input wire read_seen,
	input wire code_verified,
	input wire busy
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);
	chk_reset_state:
		assert property ($rose(arst_n) |-> por_active && !busy && !io_oe)
		else $error("bad state after reset");
	chk_por_exit:
		assert property (por_active && strobe_pin && $rose(card_clock_pin)
			|-> ##[1:6] !por_active) else $error("reset did not end");
	chk_cmd_undriven:
		assert property (strobe_pin [*8] |-> !io_oe)
		else $error("line driven during command");
	chk_strobe_release:
		assert property ($rose(strobe_pin) |-> ##[1:6] !io_oe && !busy)
		else $error("no release on strobe");
	chk_open_drain:
		assert property (io_out == 1'b0) else $error("line driven high");
	chk_busy_quiet:
		assert property (busy |-> !io_oe) else $error("low while busy");
	chk_read_first:
		assert property (!read_seen || por_active |-> !busy)
		else $error("write before read");
	chk_done_low:
		assert property ($fell(busy) && !strobe_pin |-> ##[0:2] io_oe)
		else $error("no completion low");
	chk_code_kept:
		assert property (code_verified |=> code_verified)
		else $error("verification lost");
	cover property ($fell(busy));
	cover property ($rose(code_verified));
	cover property ($rose(read_seen));
	cover property (busy && $rose(strobe_pin));
endmodule
bind pce_core pce_props i_pce_props(.clock(clock), .arst_n(arst_n),
	.strobe_pin(strobe_pin), .card_clock_pin(card_clock_pin),
	.io_in(io_in), .io_out(io_out), .io_oe(io_oe),
	.por_active(por_active), .read_seen(read_seen),
	.code_verified(code_verified), .busy(busy));

/* verification/pce_host.sv */
/*
 card reader host model: strobe, card clock, data pull-down.
 assumes a pull-up on the data wire.
*/
`timescale 1ns/1ns
module pce_host
(
	input  wire clock,
	output reg  strobe_pin,
	output reg  card_clock_pin,
	output reg  host_low
);
	initial
	begin
		strobe_pin = 1'b0;
		card_clock_pin = 1'b0;
		host_low = 1'b0;
	end
	// 7 clocks a level, above the 4 the synchronisers need
	task put(input s, input c, input b);
	begin
		@(posedge clock);
		strobe_pin <= s;
		card_clock_pin <= c;
		host_low <= s & ~b;
		repeat (6) @(posedge clock);
	end
	endtask
	// data settles while the clock is low
	task pulse(input s, input b);
	begin
		put(s, 1'b0, b);
		put(s, 1'b1, b);
	end
	endtask
	task frame(input [5:0] c, input [9:0] a, input [7:0] d);
		reg [23:0] f;
		integer    i;
	begin
		f = {d, a[7:0], a[9], a[8], c};
		put(1'b1, 1'b0, 1'b1);
		for (i = 0; i < 24; i = i + 1)
			pulse(1'b1, f[i]);
		put(1'b0, 1'b0, 1'b1);
	end
	endtask
	task atr;
	begin
		put(1'b1, 1'b0, 1'b1);
		pulse(1'b1, 1'b1);
		put(1'b0, 1'b0, 1'b1);
	end
	endtask
endmodule

/* verification/tb_top.sv */
/*
 bench for pce_core: host model drives pins, a monitor checks notes.
 assumes the secure variant with code bytes FF, FF.
*/
`timescale 1ns/1ns
module tb_top;
	reg          clock;
	reg          arst_n;
	wire         strobe_pin, card_clock_pin, host_low, io_out, io_oe;
	wire         por_active, read_seen, code_verified, busy, io_in;
	integer      err_total, checks, seed, r, n, i;
	reg   [17:0] want_q[$];
	reg   [17:0] got, want, v;
	reg   [7:0]  d;
	event        smp;
	assign io_in = ~(io_oe | host_low);
	pce_host i_pce_host(.clock(clock), .strobe_pin(strobe_pin),
		.card_clock_pin(card_clock_pin), .host_low(host_low));
	pce_core i_pce_core(.clock(clock), .arst_n(arst_n),
		.strobe_pin(strobe_pin), .card_clock_pin(card_clock_pin),
		.io_in(io_in), .io_out(io_out), .io_oe(io_oe),
		.por_active(por_active), .read_seen(read_seen),
		.code_verified(code_verified), .busy(busy));
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(smp)
	begin
		want = {18{1'bx}};
		if (want_q.size() > 0)
			want = want_q.pop_front();
		checks = checks + 1;
		if (got !== want)
		begin
			err_total = err_total + 1;
			$display("ERROR %0t got %h want %h", $time, got, want);
		end
	end
	task note(input [17:0] w, input [17:0] g);
	begin
		want_q.push_back(w);
		got = g;
		-> smp;
		#1;
	end
	endtask
	task close_out;
	begin
		$display("errors %0d checks %0d", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask
	task bits(input integer nb);
	begin
		v = 18'h0;
		for (i = 0; i < nb; i = i + 1)
		begin
			v[i] = io_in;
			i_pce_host.pulse(1'b0, 1'b1);
		end
	end
	endtask
	task rd(input [5:0] c, input [9:0] a, input integer nb);
	begin
		i_pce_host.frame(c, a, 8'h00);
		bits(nb);
	end
	endtask
	// e: 0 refused, 1 low at once, else timed pulses
	task op(input [5:0] c, input [9:0] a, input [7:0] b, input integer e);
	begin
		i_pce_host.frame(c, a, b);
		note(e > 1, busy);
		n = 0;
		while (e > 1 && io_in && n < 250)
		begin
			i_pce_host.pulse(1'b0, 1'b1);
			n = n + 1;
		end
		if (n == 250)
		begin
			err_total = err_total + 1;
			close_out;
		end
		else
		begin
			note(e > 1 ? e[17:0] : 18'h0, n[17:0]);
			note(e == 0, io_in);
		end
	end
	endtask
	initial
	begin
		err_total = 0;
		checks = 0;
		seed = 40;
		arst_n = 1'b0;
		repeat (12) @(posedge clock);
		arst_n <= 1'b1;
		repeat (2) @(posedge clock);
		note(18'h001, por_active);
		note(18'h000, io_out);
		op(6'h33, 10'h005, 8'h00, 0);
		note(18'h000, por_active);
		i_pce_host.atr;
		bits(16);
		note(18'h0FFFF, v);
		note(18'h001, read_seen);
		op(6'h33, 10'h005, 8'h00, 0);
		op(6'h32, 10'h3FD, 8'hFE, 103);
		op(6'h0D, 10'h3FE, 8'hFF, 0);
		op(6'h0D, 10'h3FF, 8'hFF, 1);
		note(18'h001, code_verified);
		r = $random(seed);
		d = (r[7:0] & 8'hFC) | 8'h02;
		op(6'h33, 10'h005, d, 103);
		op(6'h33, 10'h005, ~d, 203);
		op(6'h31, 10'h006, d, 103);
		rd(6'h0E, 10'h005, 16);
		note({2'b00, d, ~d}, v);
		op(6'h30, 10'h005, d, 0);
		op(6'h30, 10'h005, ~d, 1);
		op(6'h33, 10'h005, d, 0);
		rd(6'h0C, 10'h005, 18);
		note({1'b0, d, 1'b0, ~d}, v);
		rd(6'h0C, 10'h3FE, 9);
		// code bytes hide their flag as well as their data
		note(18'h000, v);
		// a strobe rise in mid-write must drop the timed write
		i_pce_host.frame(6'h33, 10'h007, 8'h00);
		note(18'h001, busy);
		repeat (5) i_pce_host.pulse(1'b0, 1'b1);
		rd(6'h0E, 10'h007, 8);
		note(18'h0FF, v);
		note(18'h000, busy);
		// an empty error counter refuses even the right code
		op(6'h32, 10'h3FD, 8'h00, 103);
		op(6'h0D, 10'h3FF, 8'hFF, 0);
		close_out;
	end
endmodule
